// >>> hw/sample_clock_ctrl.v
// Sample clock control: external reference PLL setup, lock wait and clock output
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
// Contract
// - Clock source value 32 routes the external reference into the PLL.
// - Reference register is read/write, range checked, and feeds PLL settings.
// - PLL stays in the path even when rate equals reference.
// - Start loads pending settings; changed settings reprogram the PLL then lock.
// - Start waits for PLL lock, up to 200 ms, before clock is stable.
// - Lock wait happens automatically within the start, no software step.
// - Failed lock refuses the start and reports a lock failure error.
// - Below converter minimum, converter runs in range with up to 256x oversampling, digital part slower; code caps at 256x even if still below range.
// - Oversampling register reads the current factor, 1 when inactive.
// - Clock output carries programmed rate times oversampling factor.
// - Output enable write 1 drives the connector, 0 makes it high impedance.
// - Output frequency register reads the synthesized clock at the output.
// - Sample rate write requests hertz; read returns nearest achievable rate.
module sample_clock_ctrl #(
    parameter [31:0] LOCK_TIMEOUT_CYC = `LOCK_TIMEOUT_CYC,
    parameter [31:0] REF_MIN_HZ = `REF_MIN_HZ,
    parameter [31:0] REF_MAX_HZ = `REF_MAX_HZ,
    parameter [31:0] ADC_MIN_HZ = `ADC_MIN_HZ,
    parameter integer OSF_MAX_LOG2 = `OSF_MAX_LOG2,
    parameter integer RATE_STEP_LOG2 = `RATE_STEP_LOG2
) (
    input wire core_clk,
    input wire srst,
    input wire [17:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg reg_rvalid,
    input wire card_start_command,
    input wire pll_lock,
    output reg pll_ref_ext_sel,
    output reg pll_bypass,
    output reg pll_program,
    output reg [31:0] pll_ref_hz,
    output reg [31:0] pll_target_hz,
    output reg [31:0] digital_rate_hz,
    output reg [31:0] digital_decim,
    output reg clk_out_oe,
    output reg sample_clock_stable,
    output reg start_busy,
    output reg start_accepted,
    output reg start_refused,
    output reg pll_lock_failure_error
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT_LOCK = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    localparam [32:0] STEP_HALF = (33'h000000001 << RATE_STEP_LOG2) >> 1;
    localparam [31:0] STEP_MASK = ~((32'h00000001 << RATE_STEP_LOG2) - 32'h00000001);

    // Pending settings written by software
    reg [31:0] pend_mode;
    reg [31:0] pend_ref;
    reg [31:0] pend_rate;
    reg out_enable;
    // Settings loaded into hardware at the last start
    reg [31:0] act_mode;
    reg [31:0] act_ref;
    reg [31:0] act_rate;
    reg programmed;

    reg [1:0] state;
    reg [31:0] lock_cnt;
    wire lock_level;
    wire [31:0] act_osf;
    wire [39:0] act_conv_hz;
    wire settings_changed;
    wire [31:0] pend_rate_near;
    wire lock_ok;
    wire lock_timeout;
    wire err_set;
    wire err_clr;

    // Nearest rate the PLL can generate on its frequency grid
    function [31:0] nearest_rate;
        input [31:0] r;
        reg [32:0] s;
        begin
            s = {1'b0, r} + STEP_HALF;
            if (s[32]) begin
                nearest_rate = r & STEP_MASK;
            end else begin
                nearest_rate = s[31:0] & STEP_MASK;
            end
        end
    endfunction

    // Reference writes outside the supported range are dropped
    function ref_in_range;
        input [31:0] f;
        begin
            ref_in_range = (f >= REF_MIN_HZ) && (f <= REF_MAX_HZ);
        end
    endfunction

    pin_sync3 lock_sync (
        .core_clk(core_clk),
        .srst(srst),
        .pin_in(pll_lock),
        .level(lock_level)
    );

    oversample_calc #(
        .ADC_MIN_HZ(ADC_MIN_HZ),
        .OSF_MAX_LOG2(OSF_MAX_LOG2)
    ) osf_unit (
        .core_clk(core_clk),
        .srst(srst),
        .rate_hz(act_rate),
        .osf(act_osf),
        .conv_hz(act_conv_hz)
    );

    assign pend_rate_near = nearest_rate(pend_rate);
    assign settings_changed = !programmed || (pend_mode != act_mode)
        || (pend_ref != act_ref) || (pend_rate_near != act_rate);

    // Lock counts only after the blank window, which hides the stale
    // synchronised level left over from before the reprogram
    assign lock_ok = lock_level && (lock_cnt >= `LOCK_BLANK_CYC);
    assign lock_timeout = (lock_cnt >= LOCK_TIMEOUT_CYC - 32'h00000001);
    // Failure flag events; a start while waiting clears nothing
    assign err_clr = card_start_command && (state == ST_IDLE || state == ST_RUN);
    assign err_set = ((state == ST_RUN) && !card_start_command && !lock_level)
        || ((state == ST_WAIT_LOCK) && !lock_ok && lock_timeout);

    // Register writes into the pending set
    always @(posedge core_clk) begin
        if (srst) begin
            pend_mode <= `RST_CLOCK_SOURCE_SELECT;
            pend_ref <= `RST_REFERENCE_FREQUENCY_HZ;
            pend_rate <= `RST_SAMPLE_RATE_HZ;
            out_enable <= `RST_CLOCK_OUTPUT_ENABLE;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_CLOCK_SOURCE_SELECT: begin
                    // Any value is stored; only 32 routes the reference
                    pend_mode <= reg_wdata;
                end
                `ADDR_REFERENCE_FREQUENCY_HZ: begin
                    if (ref_in_range(reg_wdata)) begin
                        pend_ref <= reg_wdata;
                    end
                end
                `ADDR_SAMPLE_RATE_HZ: begin
                    pend_rate <= reg_wdata;
                end
                `ADDR_CLOCK_OUTPUT_ENABLE: begin
                    out_enable <= reg_wdata[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads, answered one cycle later
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_CLOCK_SOURCE_SELECT: begin
                        reg_rdata <= pend_mode;
                    end
                    `ADDR_REFERENCE_FREQUENCY_HZ: begin
                        reg_rdata <= pend_ref;
                    end
                    `ADDR_SAMPLE_RATE_HZ: begin
                        reg_rdata <= pend_rate_near;
                    end
                    `ADDR_CLOCK_OUTPUT_ENABLE: begin
                        reg_rdata <= {31'h00000000, out_enable};
                    end
                    `ADDR_CLOCK_OUTPUT_FREQUENCY: begin
                        // Nothing synthesized at the output until lock is accepted
                        reg_rdata <= sample_clock_stable ? act_conv_hz[31:0] : 32'h00000000;
                    end
                    `ADDR_OVERSAMPLING_FACTOR: begin
                        reg_rdata <= act_osf;
                    end
                    default: begin
                        reg_rdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Start sequence with automatic lock wait
    always @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            lock_cnt <= 32'h00000000;
            act_mode <= `RST_CLOCK_SOURCE_SELECT;
            act_ref <= `RST_REFERENCE_FREQUENCY_HZ;
            act_rate <= `RST_SAMPLE_RATE_HZ;
            programmed <= 1'b0;
            pll_program <= 1'b0;
            start_busy <= 1'b0;
            start_accepted <= 1'b0;
            start_refused <= 1'b0;
            sample_clock_stable <= 1'b0;
        end else begin
            pll_program <= 1'b0;
            start_accepted <= 1'b0;
            start_refused <= 1'b0;
            case (state)
                ST_IDLE, ST_RUN: begin
                    if (card_start_command) begin
                        lock_cnt <= 32'h00000000;
                        if (settings_changed) begin
                            act_mode <= pend_mode;
                            act_ref <= pend_ref;
                            act_rate <= pend_rate_near;
                            programmed <= 1'b1;
                            pll_program <= 1'b1;
                            sample_clock_stable <= 1'b0;
                            start_busy <= 1'b1;
                            state <= ST_WAIT_LOCK;
                        end else if (lock_level && sample_clock_stable) begin
                            // Unchanged settings on a held lock need no wait
                            start_accepted <= 1'b1;
                        end else begin
                            sample_clock_stable <= 1'b0;
                            start_busy <= 1'b1;
                            state <= ST_WAIT_LOCK;
                        end
                    end else if (state == ST_RUN && !lock_level) begin
                        // Reference lost while running
                        sample_clock_stable <= 1'b0;
                        programmed <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_WAIT_LOCK: begin
                    // Starts arriving while waiting are ignored
                    lock_cnt <= lock_cnt + 32'h00000001;
                    if (lock_ok) begin
                        sample_clock_stable <= 1'b1;
                        start_accepted <= 1'b1;
                        start_busy <= 1'b0;
                        state <= ST_RUN;
                    end else if (lock_timeout) begin
                        // Out of time: refuse and force a full reprogram next start
                        start_refused <= 1'b1;
                        programmed <= 1'b0;
                        start_busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Lock failure flag, held until the next start; a set in the clear cycle wins
    always @(posedge core_clk) begin
        if (srst) begin
            pll_lock_failure_error <= 1'b0;
        end else if (err_set) begin
            pll_lock_failure_error <= 1'b1;
        end else if (err_clr) begin
            pll_lock_failure_error <= 1'b0;
        end
    end

    // PLL settings and clock output drive
    always @(posedge core_clk) begin
        if (srst) begin
            pll_ref_ext_sel <= 1'b0;
            pll_bypass <= 1'b0;
            pll_ref_hz <= 32'h00000000;
            pll_target_hz <= 32'h00000000;
            digital_rate_hz <= 32'h00000000;
            digital_decim <= `RST_OVERSAMPLING_FACTOR;
            clk_out_oe <= 1'b0;
        end else begin
            pll_ref_ext_sel <= (act_mode == `MODE_EXTERNAL_REFERENCE_PLL);
            // Held low: the PLL stays in the path even for a plain copy
            pll_bypass <= 1'b0;
            pll_ref_hz <= act_ref;
            pll_target_hz <= act_conv_hz[31:0];
            digital_rate_hz <= act_rate;
            digital_decim <= act_osf;
            clk_out_oe <= out_enable;
        end
    end
endmodule // sample_clock_ctrl

// >>> hw/clock_ctrl_consts.vh
// Offsets, reset values and timing constants of the sample clock control
`ifndef CLOCK_CTRL_CONSTS_VH
`define CLOCK_CTRL_CONSTS_VH

// Register offsets as printed (word index on the parameter port)
`define ADDR_SAMPLE_RATE_HZ 18'h04e20
`define ADDR_CLOCK_OUTPUT_ENABLE 18'h04e8e
`define ADDR_CLOCK_OUTPUT_FREQUENCY 18'h04e8f
`define ADDR_REFERENCE_FREQUENCY_HZ 18'h04eac
`define ADDR_CLOCK_SOURCE_SELECT 18'h04ee8
`define ADDR_OVERSAMPLING_FACTOR 18'h30dbb

// Clock source value
`define MODE_EXTERNAL_REFERENCE_PLL 32'h00000020

// Reset values
`define RST_CLOCK_SOURCE_SELECT 32'h00000020
`define RST_REFERENCE_FREQUENCY_HZ 32'h00989680
`define RST_SAMPLE_RATE_HZ 32'h03b9aca0
`define RST_CLOCK_OUTPUT_ENABLE 1'b0
`define RST_OVERSAMPLING_FACTOR 32'h00000001

// Supported ranges
`define REF_MIN_HZ 32'h000f4240
`define REF_MAX_HZ 32'h3b9aca00
`define ADC_MIN_HZ 32'h02faf080
`define OSF_MAX_LOG2 8
`define RATE_STEP_LOG2 4

// Timing
`define CORE_CLK_HZ 32'h05f5e100
`define LOCK_TIME_MAX_MS 32'h000000c8
`define LOCK_TIMEOUT_CYC (`LOCK_TIME_MAX_MS * (`CORE_CLK_HZ / 32'h000003e8))
`define LOCK_BLANK_CYC 32'h00000008

`endif

// >>> hw/pin_sync3.v
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module pin_sync3 (
    input wire core_clk,
    input wire srst,
    input wire pin_in,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge core_clk) begin
        if (srst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            // Change counts once stages two and three agree
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // pin_sync3

// >>> hw/oversample_calc.v
// Oversampling factor and converter clock from a programmed sample rate
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module oversample_calc #(
    parameter [31:0] ADC_MIN_HZ = `ADC_MIN_HZ,
    parameter integer OSF_MAX_LOG2 = `OSF_MAX_LOG2
) (
    input wire core_clk,
    input wire srst,
    input wire [31:0] rate_hz,
    output reg [31:0] osf,
    output reg [39:0] conv_hz
);
    reg [3:0] next_log2;
    reg found;
    integer i;

    // Smallest power of two that lifts the converter into its range, else the largest, 2^OSF_MAX_LOG2
    always @* begin
        found = 1'b0;
        next_log2 = OSF_MAX_LOG2[3:0];
        for (i = 0; i <= OSF_MAX_LOG2; i = i + 1) begin
            if (!found && (({8'h00, rate_hz} << i) >= {8'h00, ADC_MIN_HZ})) begin
                found = 1'b1;
                next_log2 = i[3:0];
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            osf <= `RST_OVERSAMPLING_FACTOR;
            conv_hz <= 40'h0000000000;
        end else begin
            osf <= 32'h00000001 << next_log2;
            conv_hz <= {8'h00, rate_hz} << next_log2;
        end
    end
endmodule // oversample_calc

// >>> tb/pll_ref_model.sv
// Behavioural PLL fed by an external reference source
`timescale 1ns/1ps
module pll_ref_model (
    input wire core_clk,
    input wire pll_program,
    input wire ref_sel,
    input wire ref_present,
    input wire [7:0] lock_delay,
    output reg pll_lock
);
    reg [7:0] cnt = 8'h0;
    initial pll_lock = 1'b0;
    // Relock after each program, only on a routed and present reference
    always @(posedge core_clk) begin
        if (pll_program || !ref_sel || !ref_present) begin
            cnt <= 8'h0;
            pll_lock <= 1'b0;
        end else if (cnt < lock_delay) begin
            cnt <= cnt + 8'h1;
        end else begin
            pll_lock <= 1'b1;
        end
    end
endmodule // pll_ref_model

// >>> tb/clock_ctrl_asserts.sv
// Port assertions for the sample clock control
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module clock_ctrl_asserts #(
    parameter [31:0] LOCK_TIMEOUT_CYC = 32'h40
) (
    input wire core_clk,
    input wire srst,
    input wire [17:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_rvalid,
    input wire card_start_command,
    input wire pll_bypass,
    input wire pll_program,
    input wire clk_out_oe,
    input wire sample_clock_stable,
    input wire start_busy,
    input wire start_accepted,
    input wire start_refused,
    input wire pll_lock_failure_error
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    reg [31:0] wait_cnt;
    always @(posedge core_clk) begin
        if (srst || !start_busy) begin
            wait_cnt <= 32'h0;
        end else begin
            wait_cnt <= wait_cnt + 32'h1;
        end
    end
    bypass_never_a: assert property (!pll_bypass)
        else $error("PLL bypass raised");
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read without answer");
    start_prog_a: assert property
        (card_start_command && !start_busy && !sample_clock_stable |=> pll_program && start_busy)
        else $error("start did not program PLL");
    busy_unstable_a: assert property (start_busy |-> !sample_clock_stable)
        else $error("stable during lock wait");
    stable_rise_a: assert property ($rose(sample_clock_stable) |-> start_accepted)
        else $error("stable without accept");
    accept_state_a: assert property (start_accepted |-> sample_clock_stable && !start_busy)
        else $error("accept state wrong");
    wait_bound_a: assert property (wait_cnt <= LOCK_TIMEOUT_CYC + 32'h2)
        else $error("lock wait too long");
    refuse_err_a: assert property
        (start_refused |-> pll_lock_failure_error && !sample_clock_stable && !start_busy)
        else $error("refusal without error");
    err_clear_a: assert property
        (card_start_command && !start_busy |=> !pll_lock_failure_error)
        else $error("error not cleared by start");
    err_sticky_a: assert property
        ($fell(pll_lock_failure_error) |-> $past(card_start_command))
        else $error("error cleared without start");
    oe_follow_a: assert property
        (reg_wr && reg_addr == `ADDR_CLOCK_OUTPUT_ENABLE |-> ##2 clk_out_oe == $past(reg_wdata[0], 2))
        else $error("output enable wrong");
endmodule // clock_ctrl_asserts

bind sample_clock_ctrl clock_ctrl_asserts #(.LOCK_TIMEOUT_CYC(LOCK_TIMEOUT_CYC)) i_chk (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .pll_bypass(pll_bypass),
    .card_start_command(card_start_command), .pll_program(pll_program),
    .clk_out_oe(clk_out_oe), .sample_clock_stable(sample_clock_stable),
    .start_busy(start_busy), .start_accepted(start_accepted), .start_refused(start_refused),
    .pll_lock_failure_error(pll_lock_failure_error));

// >>> tb/tb.sv
// Self-checking bench for the sample clock control
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module tb;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg [17:0] reg_addr = 18'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg card_start_command = 1'b0;
    reg ref_present = 1'b1;
    reg [7:0] lock_delay = 8'h14;
    reg first_prog;
    reg [31:0] waited;
    wire [31:0] reg_rdata, pll_ref_hz, pll_target_hz, digital_rate_hz, digital_decim;
    wire reg_rvalid, pll_lock, pll_ref_ext_sel, pll_bypass, pll_program, clk_out_oe;
    wire sample_clock_stable, start_busy, start_accepted, start_refused, pll_lock_failure_error;
    integer err_total = 0;
    integer checks_done = 0;
    integer i;
    typedef struct packed {logic w; logic [17:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    row_t rows [0:11];
    sample_clock_ctrl #(.LOCK_TIMEOUT_CYC(32'h40)) i_dut (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .card_start_command(card_start_command), .pll_lock(pll_lock),
        .pll_ref_ext_sel(pll_ref_ext_sel), .pll_bypass(pll_bypass), .pll_program(pll_program),
        .pll_ref_hz(pll_ref_hz), .pll_target_hz(pll_target_hz),
        .digital_rate_hz(digital_rate_hz), .digital_decim(digital_decim),
        .clk_out_oe(clk_out_oe), .sample_clock_stable(sample_clock_stable),
        .start_busy(start_busy), .start_accepted(start_accepted), .start_refused(start_refused),
        .pll_lock_failure_error(pll_lock_failure_error));
    pll_ref_model i_pll (.core_clk(core_clk), .pll_program(pll_program),
        .ref_sel(pll_ref_ext_sel), .ref_present(ref_present), .lock_delay(lock_delay),
        .pll_lock(pll_lock));
    always #5 core_clk = ~core_clk;
    task complete_run;
        $display("err_total %0d checks_done %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp, input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wr(input [17:0] a, input [31:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task rd(input [17:0] a, input [31:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1, "rvalid");
        chk(reg_rdata, e, "rdata");
    endtask
    // Start pulse, then bounded wait for accept or refuse
    task start(input [31:0] exp_acc);
        @(negedge core_clk);
        card_start_command = 1'b1;
        @(negedge core_clk);
        card_start_command = 1'b0;
        first_prog = pll_program;
        waited = 32'h0;
        while (start_accepted !== 1'b1 && start_refused !== 1'b1 && waited < 32'h96) begin
            @(negedge core_clk);
            waited = waited + 32'h1;
        end
        chk({31'h0, start_accepted}, exp_acc, "accept");
        if (waited == 32'h96) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t start wait timed out", $time);
            complete_run();
        end
    endtask
    initial begin
        rows[0] = {1'b0, `ADDR_CLOCK_SOURCE_SELECT, 32'h0, 32'h20};
        rows[1] = {1'b0, `ADDR_REFERENCE_FREQUENCY_HZ, 32'h0, 32'h00989680};
        rows[2] = {1'b0, `ADDR_SAMPLE_RATE_HZ, 32'h0, 32'h03b9aca0};
        rows[3] = {1'b0, `ADDR_CLOCK_OUTPUT_ENABLE, 32'h0, 32'h0};
        rows[4] = {1'b0, `ADDR_OVERSAMPLING_FACTOR, 32'h0, 32'h1};
        rows[5] = {1'b1, 18'h00001, 32'h5, 32'h0};
        rows[6] = {1'b1, `ADDR_REFERENCE_FREQUENCY_HZ, 32'h0007a120, 32'h00989680};
        rows[7] = {1'b1, `ADDR_SAMPLE_RATE_HZ, 32'h03b9aca7, 32'h03b9aca0};
        rows[8] = {1'b1, `ADDR_SAMPLE_RATE_HZ, 32'h03b9aca8, 32'h03b9acb0};
        rows[9] = {1'b1, `ADDR_CLOCK_OUTPUT_ENABLE, 32'h3, 32'h1};
        rows[10] = {1'b1, `ADDR_OVERSAMPLING_FACTOR, 32'h5, 32'h1};
        rows[11] = {1'b1, `ADDR_REFERENCE_FREQUENCY_HZ, 32'h01312d00, 32'h01312d00};
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(`ADDR_REFERENCE_FREQUENCY_HZ, 32'h00989680);
        wr(`ADDR_SAMPLE_RATE_HZ, 32'h00989680);
        start(32'h1);
        chk({31'h0, first_prog}, 32'h1, "program");
        chk({31'h0, waited > 32'h14}, 32'h1, "lock wait");
        chk({30'h0, pll_ref_ext_sel, pll_bypass}, 32'h2, "path");
        chk(pll_ref_hz, 32'h00989680, "ref");
        chk(pll_target_hz, 32'h04c4b400, "target");
        chk(digital_rate_hz, 32'h00989680, "digital");
        chk(digital_decim, 32'h8, "decim");
        chk({31'h0, clk_out_oe}, 32'h1, "oe");
        rd(`ADDR_OVERSAMPLING_FACTOR, 32'h8);
        rd(`ADDR_CLOCK_OUTPUT_FREQUENCY, 32'h04c4b400);
        start(32'h1);
        chk({first_prog, waited[30:0]}, 32'h0, "no reprogram");
        ref_present = 1'b0;
        repeat (8) @(negedge core_clk);
        chk({30'h0, sample_clock_stable, pll_lock_failure_error}, 32'h1, "loss");
        start(32'h0);
        chk({31'h0, waited > 32'h3c && waited < 32'h44}, 32'h1, "timeout");
        chk({31'h0, start_busy}, 32'h0, "busy after refuse");
        repeat (5) @(negedge core_clk);
        chk({31'h0, pll_lock_failure_error}, 32'h1, "sticky");
        rd(`ADDR_CLOCK_OUTPUT_FREQUENCY, 32'h0);
        ref_present = 1'b1;
        lock_delay = 8'h1;
        start(32'h1);
        chk({31'h0, pll_lock_failure_error}, 32'h0, "err clear");
        wr(`ADDR_CLOCK_SOURCE_SELECT, 32'h1);
        start(32'h0);
        chk({31'h0, pll_ref_ext_sel}, 32'h0, "no ext");
        wr(`ADDR_CLOCK_SOURCE_SELECT, `MODE_EXTERNAL_REFERENCE_PLL);
        start(32'h1);
        wr(`ADDR_CLOCK_OUTPUT_ENABLE, 32'h0);
        repeat (2) @(negedge core_clk);
        chk({31'h0, clk_out_oe}, 32'h0, "tristate");
        srst = 1'b1;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        chk({sample_clock_stable, digital_decim[30:0]}, 32'h1, "reset");
        rd(`ADDR_SAMPLE_RATE_HZ, 32'h03b9aca0);
        complete_run();
    end
endmodule // tb
